// file: common/ptb_pkg.sv
// Package for the PWM time base clock and sync configuration slice
package ptb_pkg;

	// Word offsets on the Wishbone bus (byte addresses)
	localparam logic [3:0] ADDR_TIMEBASE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CLOCK_DIVIDER    = 4'h4;

	// Timebase control field positions
	localparam int TBC_RUN_BIT  = 15;
	localparam int TBC_SYNC_LSB = 4;
	localparam int TBC_SYNC_MSB = 6;
	localparam int TBC_POST_LSB = 0;
	localparam int TBC_POST_MSB = 3;
	// Divider select field positions
	localparam int CDS_DIV_LSB  = 0;
	localparam int CDS_DIV_MSB  = 2;

	// Reset values
	localparam logic [2:0] RST_SYNC_SRC = 3'h0;
	localparam logic [3:0] RST_POSTSCALE = 4'h0;
	localparam logic [2:0] RST_CLK_DIV  = 3'h0;

	// Codes
	localparam logic [2:0] SYNC_SRC_EXTERNAL = 3'h0;
	localparam logic [2:0] CLK_DIV_RESERVED  = 3'h7;
	localparam logic [6:0] PRESCALE_MAX      = 7'h3f;

	// Configuration carried to the prescaler, sync select and postscaler
	typedef struct packed {
		logic       run;
		logic [2:0] sync_src;
		logic [3:0] postscale;
		logic [2:0] clk_div;
	} ptb_cfg_t;

endpackage

// file: core/ptb_prescaler.sv
// Input clock prescaler: one-cycle enable pulse at mclk / 2^div, no pulse for the reserved code 7
module ptb_prescaler (
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       run_i,
	input  wire logic [2:0] div_i,
	output logic            tick_o
);
	logic [6:0] cnt_r;
	logic [6:0] limit;

	// Limit is 2^div - 1, masked to 63 for the reserved code, whose ticks are gated off at tick_o
	always_comb begin
		limit = 7'(({7'h0, 1'b1} << div_i) - 7'h1) & ptb_pkg::PRESCALE_MAX;
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i || !run_i) begin
			cnt_r <= 7'h0;
		end else if (cnt_r >= limit) begin
			cnt_r <= 7'h0;
		end else begin
			cnt_r <= cnt_r + 7'h1;
		end
	end

	assign tick_o = run_i && (div_i != ptb_pkg::CLK_DIV_RESERVED) && (cnt_r >= limit);
endmodule // ptb_prescaler

// file: core/ptb_timebase_cfg.sv
// PWM time base configuration: prescaler, sync select, event postscaler
module ptb_timebase_cfg (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// Classic Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// Time base side
	input  wire logic        ext_sync_pin_i,
	input  wire logic        compare_match_i,
	output logic             clk_tick_o,
	output logic             sync_pulse_o,
	output logic             event_trigger_o,
	output logic             timebase_run_o
);
	ptb_pkg::ptb_cfg_t cfg_r;
	logic [3:0]        post_cnt_r;
	logic              sync_m_r;
	logic              sync_s_r;
	logic              sync_d_r;
	logic              trig_r;
	logic              ack_r;
	logic              err_r;
	logic [31:0]       rdat_r;
	logic              req;
	logic              hit_ctl;
	logic              hit_div;

	assign req     = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
	assign hit_ctl = wb_adr_i == ptb_pkg::ADDR_TIMEBASE_CONTROL;
	assign hit_div = wb_adr_i == ptb_pkg::ADDR_CLOCK_DIVIDER;

	// Bus answer one cycle after the request; unmapped addresses get err
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			ack_r <= req && (hit_ctl || hit_div);
			err_r <= req && !(hit_ctl || hit_div);
		end
	end

	// Fields are written whatever the run state; keeping them still while running is software's job
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cfg_r.run       <= 1'b0;
			cfg_r.sync_src  <= ptb_pkg::RST_SYNC_SRC;
			cfg_r.postscale <= ptb_pkg::RST_POSTSCALE;
			cfg_r.clk_div   <= ptb_pkg::RST_CLK_DIV;
		end else if (req && wb_we_i) begin
			if (hit_ctl && wb_sel_i[0]) begin
				cfg_r.sync_src  <= wb_dat_i[ptb_pkg::TBC_SYNC_MSB:ptb_pkg::TBC_SYNC_LSB];
				cfg_r.postscale <= wb_dat_i[ptb_pkg::TBC_POST_MSB:ptb_pkg::TBC_POST_LSB];
			end
			if (hit_ctl && wb_sel_i[1]) begin
				cfg_r.run <= wb_dat_i[ptb_pkg::TBC_RUN_BIT];
			end
			if (hit_div && wb_sel_i[0]) begin
				cfg_r.clk_div <= wb_dat_i[ptb_pkg::CDS_DIV_MSB:ptb_pkg::CDS_DIV_LSB];
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdat_r <= 32'h0;
		end else if (req) begin
			rdat_r <= 32'h0;
			if (hit_ctl) begin
				rdat_r[ptb_pkg::TBC_RUN_BIT] <= cfg_r.run;
				rdat_r[ptb_pkg::TBC_SYNC_MSB:ptb_pkg::TBC_SYNC_LSB] <= cfg_r.sync_src;
				rdat_r[ptb_pkg::TBC_POST_MSB:ptb_pkg::TBC_POST_LSB] <= cfg_r.postscale;
			end else if (hit_div) begin
				rdat_r[ptb_pkg::CDS_DIV_MSB:ptb_pkg::CDS_DIV_LSB] <= cfg_r.clk_div;
			end
		end
	end

	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign wb_err_o = err_r;

	ptb_prescaler u_prescaler (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.run_i    (cfg_r.run),
		.div_i    (cfg_r.clk_div),
		.tick_o   (clk_tick_o)
	);

	// Pin passes two flops before the edge detector reads it
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sync_m_r <= 1'b0;
			sync_s_r <= 1'b0;
			sync_d_r <= 1'b0;
		end else begin
			sync_m_r <= ext_sync_pin_i;
			sync_s_r <= sync_m_r;
			sync_d_r <= sync_s_r;
		end
	end

	// Only code 000 routes the external input; reserved codes give nothing
	assign sync_pulse_o = cfg_r.run && (cfg_r.sync_src == ptb_pkg::SYNC_SRC_EXTERNAL)
		&& sync_s_r && !sync_d_r;

	// Postscaler counts matches while running and restarts on stop
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || !cfg_r.run) begin
			post_cnt_r <= 4'h0;
			trig_r     <= 1'b0;
		end else if (compare_match_i) begin
			if (post_cnt_r >= cfg_r.postscale) begin
				post_cnt_r <= 4'h0;
				trig_r     <= 1'b1;
			end else begin
				post_cnt_r <= post_cnt_r + 4'h1;
				trig_r     <= 1'b0;
			end
		end else begin
			trig_r <= 1'b0;
		end
	end

	assign event_trigger_o = trig_r;
	assign timebase_run_o  = cfg_r.run;
endmodule // ptb_timebase_cfg

// file: tb/ptb_far.sv
// Far-side model: compare match source and external sync pin
module ptb_far (
	input  wire logic mclk_i,
	input  wire logic en_i,
	output logic      match_o,
	output logic      sync_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ph_r = 4'h0;
	always @(posedge mclk_i) ph_r <= ph_r + 4'h1;
	// Lines rest low between bursts, as a pull-down leaves them
	assign match_o = en_i;
	assign sync_o = en_i & ph_r[3];
endmodule // ptb_far

// file: tb/ptb_chk_chk.sv
// Assertions on the outputs of the time base configuration slice
module ptb_chk (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ext_sync_pin_i,
	input wire logic compare_match_i,
	input wire logic clk_tick_o,
	input wire logic sync_pulse_o,
	input wire logic event_trigger_o,
	input wire logic timebase_run_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	a_trig_cause: assert property (
		event_trigger_o |-> $past(compare_match_i & timebase_run_o)) else $error("stray trigger");
	a_trig_idle: assert property (
		!timebase_run_o ##1 !timebase_run_o |-> !event_trigger_o) else $error("trigger when off");
	a_tick_run: assert property (clk_tick_o |-> timebase_run_o)
		else $error("tick when off");
	a_sync_src: assert property (
		sync_pulse_o |-> $past(ext_sync_pin_i, 2) | $past(ext_sync_pin_i, 3)) else $error("stray sync");
	a_sync_once: assert property (sync_pulse_o |=> !sync_pulse_o)
		else $error("sync too wide");
endmodule // ptb_chk
bind ptb_timebase_cfg ptb_chk u_chk (.*);

// file: tb/tb_ptb_timebase_cfg.sv
// Self-checking bench for the time base configuration slice
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb_ptb_timebase_cfg;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = '0, resetn_i = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, en = '0;
	logic [3:0] wb_adr_i = '0, wb_sel_i = 4'h3, n;
	logic [31:0] wb_dat_i = '0, wb_dat_o, c = '0, seed = 32'h16cd;
	logic wb_ack_o, wb_err_o, clk_tick_o, sync_pulse_o, event_trigger_o, timebase_run_o;
	logic ext_sync_pin_i, compare_match_i;
	logic [32:0] q[$], ex;
	int fails = 0, n_tests = 0, cyc_n = 0, g, k;
	ptb_timebase_cfg u_dut (.*);
	ptb_far u_far (.mclk_i, .en_i(en), .match_o(compare_match_i), .sync_o(ext_sync_pin_i));
	initial forever #4 mclk_i = ~mclk_i;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [32:0] e = '0);
		if (!w) q.push_back(e);
		@(posedge mclk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		@(posedge mclk_i iff (wb_ack_o | wb_err_o));
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	// Fields only move while stopped: stop with old fields, set, then run
	task automatic go(input logic [3:0] a, input logic [31:0] v, r);
		wb(1, 4'h0, c);
		c = r;
		wb(1, a, v);
		wb(1, 4'h0, 32'h8000 | r);
	endtask
	task automatic gap;
		@(posedge mclk_i iff clk_tick_o);
		do begin
			@(posedge mclk_i);
			g++;
		end while (!clk_tick_o);
	endtask
	always @(posedge mclk_i) begin
		cyc_n++;
		k += (event_trigger_o === 1'h1);
		if (cyc_n > 20000) begin
			fails++;
			end_sim();
		end
		if ((wb_ack_o | wb_err_o) && !wb_we_i) begin
			ex = q.pop_front();
			`CHK("read", ex, {wb_err_o, wb_dat_o})
		end
	end
	initial begin
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'h1;
		wb(0, 4'h0, 0, 33'h0);
		wb(0, 4'h4, 0, 33'h0);
		wb(0, 4'hc, 0, 33'h100000000);
		$display("reset test done");
		repeat (4) begin
			seed = xs(seed);
			n = seed[3:0];
			go(4'h0, n, n);
			`CHK("run", 1'h1, timebase_run_o)
			k = 0;
			en <= 1'h1;
			repeat (16 * n + 16 + n) @(posedge mclk_i);
			en <= 1'h0;
			repeat (3) @(posedge mclk_i);
			`CHK("triggers", 16, k)
		end
		$display("postscale test done");
		for (int d = 0; d < 8; d++) begin
			go(4'h4, d, 0);
			g = 0;
			if (d < 7) gap();
			else repeat (200) @(posedge mclk_i) g += clk_tick_o;
			`CHK("tick gap", d < 7 ? 1 << d : 0, g)
		end
		wb(0, 4'h0, 0, 33'h8000);
		wb(0, 4'h4, 0, 33'h7);
		$display("divider test done");
		for (int s = 0; s < 8; s++) begin
			go(4'h0, s << 4, s << 4);
			g = 0;
			en <= 1'h1;
			repeat (64) @(posedge mclk_i) g += sync_pulse_o;
			en <= 1'h0;
			`CHK("sync", s == 0, g != 0)
		end
		$display("sync test done");
		end_sim();
	end
endmodule // tb_ptb_timebase_cfg
